// [inc/csf_regs.svh]
// Register offsets, bit positions, reset values and flag masks of the status flag register.
// Assumes inclusion by every design file that decodes the register or its fields.
`ifndef CSF_REGS_SVH
`define CSF_REGS_SVH

// Status register index within a bank; it is mirrored in all four banks
`define CSF_STATUS_IDX    7'h03
`define CSF_ADDR_W        9
`define CSF_BANK_OFS_W    7

// Field positions
`define CSF_BIT_IRP       7
`define CSF_BIT_RP1       6
`define CSF_BIT_RP0       5
`define CSF_BIT_TO        4
`define CSF_BIT_PD        3
`define CSF_BIT_Z         2
`define CSF_BIT_DC        1
`define CSF_BIT_C         0
`define CSF_BANK_HI       7
`define CSF_BANK_LO       5
`define CSF_FLAG_HI       2
`define CSF_BYTE_MSB      7
`define CSF_BYTE_LSB      0

// Reset value: bank bits clear, both reset-cause bits set, arithmetic flags cleared
`define CSF_STATUS_RST    8'h18
// Cleared value of the result and read registers; a missed read returns it too
`define CSF_DATA_ZERO     8'h00

// Which arithmetic flags an operation produces, as {zero, nibble carry, carry}
`define CSF_AFF_NONE      3'h0
`define CSF_AFF_ALL       3'h7
`define CSF_AFF_Z         3'h4
`define CSF_AFF_C         3'h1

`endif

// [inc/csf_pkg.sv]
// Types shared by the status flag register and its flag calculator.
// Assumes nothing beyond a SystemVerilog compiler.
package csf_pkg;

	typedef enum logic [3:0] {
		CSF_OP_NONE       = 4'h0,
		CSF_OP_MOVE_W     = 4'h1,
		CSF_OP_ADD        = 4'h2,
		CSF_OP_SUB        = 4'h3,
		CSF_OP_AND        = 4'h4,
		CSF_OP_IOR        = 4'h5,
		CSF_OP_XOR        = 4'h6,
		CSF_OP_COM        = 4'h7,
		CSF_OP_INC        = 4'h8,
		CSF_OP_DEC        = 4'h9,
		CSF_OP_CLEAR_FILE = 4'ha,
		CSF_OP_SWAP       = 4'hb,
		CSF_OP_ROT_LEFT   = 4'hc,
		CSF_OP_ROT_RIGHT  = 4'hd,
		CSF_OP_BIT_CLEAR  = 4'he,
		CSF_OP_BIT_SET    = 4'hf
	} csf_op_t;

endpackage : csf_pkg

// [inc/csf_alu_if.sv]
// Operands in, result and flags out, between the status register and its flag calculator.
// Assumes csf_pkg is compiled first.
`timescale 1ns/100ps
interface csf_alu_if;
	csf_pkg::csf_op_t op;
	logic [7:0]       a;
	logic [7:0]       b;
	logic             cin;
	logic [2:0]       bit_idx;
	logic [7:0]       result;
	logic [2:0]       flags;
	logic [2:0]       affect;

	modport req  (output op, a, b, cin, bit_idx, input result, flags, affect);
	modport calc (input op, a, b, cin, bit_idx, output result, flags, affect);
endinterface : csf_alu_if

// [verilog/csf_alu_flags.sv]
// Combinational result and flag calculator for one executed operation.
// Assumes operands are stable for the cycle; a is the working register, b the file or literal.
`timescale 1ns/100ps
`include "csf_regs.svh"
module csf_alu_flags (
	csf_alu_if.calc alu
);
	import csf_pkg::*;

	logic [8:0] sum9;
	logic [4:0] nib5;
	logic [7:0] res;
	logic [2:0] fl;
	logic [2:0] aff;

	always_comb begin
		sum9 = 9'h000;
		nib5 = 5'h00;
		res  = alu.b;
		fl   = 3'h0;
		aff  = `CSF_AFF_NONE;
		unique case (alu.op)
			CSF_OP_NONE: begin
				res = alu.b;
			end
			CSF_OP_MOVE_W: begin
				res = alu.a;
			end
			CSF_OP_ADD: begin
				nib5 = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
				sum9 = {1'b0, alu.a} + {1'b0, alu.b};
				res  = sum9[7:0];
				aff  = `CSF_AFF_ALL;
			end
			CSF_OP_SUB: begin
				// Two's complement add, so carries read as inverted borrows
				nib5 = {1'b0, alu.b[3:0]} + {1'b0, ~alu.a[3:0]} + 5'h01;
				sum9 = {1'b0, alu.b} + {1'b0, ~alu.a} + 9'h001;
				res  = sum9[7:0];
				aff  = `CSF_AFF_ALL;
			end
			CSF_OP_AND: begin
				res = alu.a & alu.b;
				aff = `CSF_AFF_Z;
			end
			CSF_OP_IOR: begin
				res = alu.a | alu.b;
				aff = `CSF_AFF_Z;
			end
			CSF_OP_XOR: begin
				res = alu.a ^ alu.b;
				aff = `CSF_AFF_Z;
			end
			CSF_OP_COM: begin
				res = ~alu.b;
				aff = `CSF_AFF_Z;
			end
			CSF_OP_INC: begin
				res = alu.b + 8'h01;
				aff = `CSF_AFF_Z;
			end
			CSF_OP_DEC: begin
				res = alu.b - 8'h01;
				aff = `CSF_AFF_Z;
			end
			CSF_OP_CLEAR_FILE: begin
				res = 8'h00;
				aff = `CSF_AFF_Z;
			end
			CSF_OP_SWAP: begin
				res = {alu.b[3:0], alu.b[7:4]};
			end
			CSF_OP_ROT_LEFT: begin
				res = {alu.b[6:0], alu.cin};
				fl[`CSF_BIT_C] = alu.b[7];
				aff = `CSF_AFF_C;
			end
			CSF_OP_ROT_RIGHT: begin
				res = {alu.cin, alu.b[7:1]};
				fl[`CSF_BIT_C] = alu.b[0];
				aff = `CSF_AFF_C;
			end
			CSF_OP_BIT_CLEAR: begin
				res = alu.b & ~(8'h01 << alu.bit_idx);
			end
			CSF_OP_BIT_SET: begin
				res = alu.b | (8'h01 << alu.bit_idx);
			end
		endcase
		if (aff == `CSF_AFF_ALL) begin
			fl[`CSF_BIT_DC] = nib5[4];
			fl[`CSF_BIT_C]  = sum9[8];
		end
		fl[`CSF_BIT_Z] = (res == 8'h00);
	end

	assign alu.result = res;
	assign alu.flags  = fl;
	assign alu.affect = aff;

endmodule : csf_alu_flags

// [verilog/csf_status_reg.sv]
// Processor status register: ALU flags, reset-cause bits and data-memory bank selection.
// Assumes the execution unit presents one retiring operation per cycle on the exec_ ports
// and that the reset-cause events come from logic on the same clock.
`timescale 1ns/100ps
`include "csf_regs.svh"

// What this block does
// - Status register may be the destination of any instruction like other file registers.
// - Flag-affecting operation writing status loads the flags it affects from flags; the other flags keep their value.
// - Software writes to watchdog-expiry and sleep-entry bits are ignored.
// - Clear-file on status zeroes bank bits, sets zero, keeps reset-cause and carries.
// - Subtraction gives carry as inverted borrow, nibble carry as inverted nibble borrow.
// - Top bit extends indirect addresses: set selects 100h-1FFh, clear 00h-FFh.
// - Same register answers at 03h, 83h, 103h and 183h.
// - One byte holds arithmetic flags, reset-cause bits and bank selection.
module csf_status_reg (
	input  wire logic             clk_sys,
	input  wire logic             srst,
	input  wire logic             exec_valid,
	input  wire csf_pkg::csf_op_t exec_op,
	input  wire logic [7:0]       exec_w,
	input  wire logic [7:0]       exec_src,
	input  wire logic [2:0]       exec_bit,
	input  wire logic             exec_dest_file,
	input  wire logic [8:0]       exec_dest_addr,
	input  wire logic [8:0]       rd_addr,
	input  wire logic             wdt_timeout_evt,
	input  wire logic             sleep_evt,
	input  wire logic             wdt_clear_evt,
	input  wire logic [6:0]       dir_offset,
	input  wire logic [7:0]       fsr_ptr,
	output logic      [7:0]       rd_data,
	output logic                  rd_hit,
	output logic      [7:0]       alu_result,
	output logic      [7:0]       status,
	output logic      [8:0]       dir_addr,
	output logic      [8:0]       ind_addr
);
	import csf_pkg::*;

	logic [7:0] status_ff;
	logic [7:0] nxt_status;
	logic [7:0] alu_result_ff;
	logic [7:0] rd_data_ff;
	logic       rd_hit_ff;
	logic       dest_hit;
	logic       rd_sel;
	logic       any_evt;

	csf_alu_if alu ();

	csf_alu_flags u_flags (
		.alu (alu)
	);

	assign alu.op      = exec_valid ? exec_op : CSF_OP_NONE;
	assign alu.a       = exec_w;
	assign alu.b       = exec_src;
	assign alu.cin     = status_ff[`CSF_BIT_C];
	assign alu.bit_idx = exec_bit;

	// Only the bank offset is decoded, so every bank sees the one register
	assign dest_hit = exec_valid && exec_dest_file &&
	                  (exec_dest_addr[`CSF_BANK_OFS_W-1:0] == `CSF_STATUS_IDX);
	assign rd_sel   = (rd_addr[`CSF_BANK_OFS_W-1:0] == `CSF_STATUS_IDX);
	assign any_evt  = wdt_timeout_evt || sleep_evt || wdt_clear_evt;

	always_comb begin
		nxt_status = status_ff;
		if (dest_hit) begin
			// Bank bits take the written data
			nxt_status[`CSF_BANK_HI:`CSF_BANK_LO] = alu.result[`CSF_BANK_HI:`CSF_BANK_LO];
		end
		for (int i = 0; i <= `CSF_FLAG_HI; i++) begin
			if (alu.affect[i]) begin
				nxt_status[i] = alu.flags[i];
			// Any flag-producing operation blocks the data write to all three flags
			end else if (dest_hit && (alu.affect == `CSF_AFF_NONE)) begin
				nxt_status[i] = alu.result[i];
			end
		end
		// Reset-cause bits move only on hardware events, never on data
		if (wdt_clear_evt) begin
			nxt_status[`CSF_BIT_TO] = 1'b1;
			nxt_status[`CSF_BIT_PD] = 1'b1;
		end
		if (sleep_evt) begin
			nxt_status[`CSF_BIT_TO] = 1'b1;
			nxt_status[`CSF_BIT_PD] = 1'b0;
		end
		// A time-out during sleep must still be visible, so it is applied last
		if (wdt_timeout_evt) begin
			nxt_status[`CSF_BIT_TO] = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			status_ff <= `CSF_STATUS_RST;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// Held between operations so a late look at the result still sees it
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			alu_result_ff <= `CSF_DATA_ZERO;
		end else if (exec_valid) begin
			alu_result_ff <= alu.result;
		end
	end

	// Read port: one cycle latency, zero when the address is not the status register
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd_data_ff <= `CSF_DATA_ZERO;
			rd_hit_ff  <= 1'b0;
		end else begin
			rd_data_ff <= rd_sel ? status_ff : `CSF_DATA_ZERO;
			rd_hit_ff  <= rd_sel;
		end
	end

	assign rd_data    = rd_data_ff;
	assign rd_hit     = rd_hit_ff;
	assign alu_result = alu_result_ff;
	assign status     = status_ff;
	// Address extension is combinational so the same-cycle access uses current bank bits
	assign dir_addr   = {status_ff[`CSF_BIT_RP1], status_ff[`CSF_BIT_RP0], dir_offset};
	assign ind_addr   = {status_ff[`CSF_BIT_IRP], fsr_ptr};

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	a_cause_bits_hold: assert property (
		!any_evt |=> status_ff[`CSF_BIT_TO:`CSF_BIT_PD] == $past(status_ff[`CSF_BIT_TO:`CSF_BIT_PD]))
		else $error("reset-cause bits changed without a hardware event");

	a_clear_file_status: assert property (
		(dest_hit && exec_op == CSF_OP_CLEAR_FILE && !any_evt) |=>
		(status_ff[`CSF_BANK_HI:`CSF_BANK_LO] == 3'h0) && status_ff[`CSF_BIT_Z] &&
		(status_ff[`CSF_BIT_TO:`CSF_BIT_PD] == $past(status_ff[`CSF_BIT_TO:`CSF_BIT_PD])) &&
		(status_ff[`CSF_BIT_DC:`CSF_BIT_C] == $past(status_ff[`CSF_BIT_DC:`CSF_BIT_C])))
		else $error("clear-file on status gave the wrong pattern");

	a_flags_override: assert property (
		(dest_hit && exec_op == CSF_OP_ADD) |=>
		status_ff[`CSF_BIT_C] == (({1'b0, $past(exec_w)} + {1'b0, $past(exec_src)}) > 9'h0ff))
		else $error("add to status did not load carry from the result");

	a_sub_borrow: assert property (
		(exec_valid && exec_op == CSF_OP_SUB) |=>
		(status_ff[`CSF_BIT_C] == ($past(exec_src) >= $past(exec_w))) &&
		(status_ff[`CSF_BIT_DC] == ($past(exec_src[3:0]) >= $past(exec_w[3:0]))))
		else $error("subtract carry is not the inverted borrow");

	a_status_mirror: assert property (
		rd_sel |=> rd_hit && (rd_data == $past(status_ff)))
		else $error("status read at a mirror address differs");

	a_indirect_bank: assert property (
		ind_addr[`CSF_ADDR_W-1] == status_ff[`CSF_BIT_IRP] && ind_addr[7:0] == fsr_ptr)
		else $error("indirect address not extended by the bank bit");

	a_direct_bank: assert property (
		dir_addr[`CSF_ADDR_W-1:`CSF_BANK_OFS_W] == status_ff[`CSF_BIT_RP1:`CSF_BIT_RP0])
		else $error("direct address bank does not follow bank bits");

	a_zero_flag: assert property (
		(exec_valid && alu.affect[`CSF_BIT_Z]) |=> status_ff[`CSF_BIT_Z] == (alu_result_ff == 8'h00))
		else $error("zero flag does not match the result");

	a_move_to_status: assert property (
		(dest_hit && exec_op == CSF_OP_MOVE_W) |=>
		status_ff[`CSF_BANK_HI:`CSF_BANK_LO] == $past(exec_w[`CSF_BANK_HI:`CSF_BANK_LO]) &&
		status_ff[`CSF_BIT_DC:`CSF_BIT_C] == $past(exec_w[`CSF_BIT_DC:`CSF_BIT_C]))
		else $error("move to status did not store the written bits");

	// Reset is checked with its own disable, since the default one would hide it
	a_reset_value: assert property (@(posedge clk_sys) disable iff (1'b0)
		srst |=> status_ff == `CSF_STATUS_RST && !rd_hit_ff && rd_data_ff == `CSF_DATA_ZERO &&
		alu_result_ff == `CSF_DATA_ZERO)
		else $error("status did not take its reset value");

	a_flag_write_block: assert property (
		(exec_valid && alu.affect == `CSF_AFF_Z) |=>
		status_ff[`CSF_BIT_DC:`CSF_BIT_C] == $past(status_ff[`CSF_BIT_DC:`CSF_BIT_C]))
		else $error("carry flags moved on a zero-only operation");

	a_rotate_status: assert property (
		(dest_hit && alu.affect == `CSF_AFF_C) |=>
		status_ff[`CSF_BIT_Z:`CSF_BIT_DC] == $past(status_ff[`CSF_BIT_Z:`CSF_BIT_DC]))
		else $error("rotate into status wrote zero or nibble carry");

	a_rotate_left: assert property (
		(exec_valid && exec_op == CSF_OP_ROT_LEFT) |=>
		status_ff[`CSF_BIT_C] == $past(exec_src[`CSF_BYTE_MSB]))
		else $error("rotate left did not load carry from the top bit");

	a_rotate_right: assert property (
		(exec_valid && exec_op == CSF_OP_ROT_RIGHT) |=>
		status_ff[`CSF_BIT_C] == $past(exec_src[`CSF_BYTE_LSB]))
		else $error("rotate right did not load carry from the bottom bit");

	a_add_nibble: assert property (
		(exec_valid && exec_op == CSF_OP_ADD) |=>
		status_ff[`CSF_BIT_DC] == (({1'b0, $past(exec_w[3:0])} + {1'b0, $past(exec_src[3:0])}) > 5'h0f))
		else $error("add did not capture the carry out of bit 3");

	a_timeout_wins: assert property (
		wdt_timeout_evt |=> !status_ff[`CSF_BIT_TO])
		else $error("watchdog time-out not shown in status");

	a_sleep_entry: assert property (
		(sleep_evt && !wdt_timeout_evt) |=> status_ff[`CSF_BIT_TO] && !status_ff[`CSF_BIT_PD])
		else $error("sleep entry not shown in status");

	a_read_miss: assert property (
		!rd_sel |=> !rd_hit && rd_data == `CSF_DATA_ZERO)
		else $error("read of another address returned status data");

	a_bank_write: assert property (
		dest_hit |=> status_ff[`CSF_BANK_HI:`CSF_BANK_LO] == $past(alu.result[`CSF_BANK_HI:`CSF_BANK_LO]))
		else $error("bank bits did not take the written data");

endmodule : csf_status_reg

// [testbench/csf_exec_model.sv]
// Execution unit stand-in: retires one operation per call on the exec_ ports.
// Assumes the caller runs on clk_sys; drives after the falling edge.
`timescale 1ns/100ps
module csf_exec_model (
	input  wire logic        clk_sys,
	output logic             exec_valid,
	output csf_pkg::csf_op_t exec_op,
	output logic [7:0]       exec_w,
	output logic [7:0]       exec_src,
	output logic [2:0]       exec_bit,
	output logic             exec_dest_file,
	output logic [8:0]       exec_dest_addr
);
	import csf_pkg::*;
	initial begin
		exec_valid = 1'b0;
		exec_op = CSF_OP_NONE;
		{exec_w, exec_src, exec_bit, exec_dest_file, exec_dest_addr} = '0;
	end
	// Callers alter status with flag-free moves where they mean a plain write
	task issue(input csf_op_t op, input logic [7:0] w, input logic [7:0] src, input logic dst,
		input logic [8:0] adr);
		@(negedge clk_sys);
		exec_valid = 1'b1;
		exec_op = op;
		exec_w = w;
		exec_src = src;
		exec_dest_file = dst;
		exec_dest_addr = adr;
		@(negedge clk_sys);
		exec_valid = 1'b0;
		exec_op = CSF_OP_NONE;
		// Released operands turn over so a held value cannot pass for a fresh one
		exec_w = ~w;
		exec_src = ~src;
		exec_dest_addr = ~adr;
	endtask : issue
	// Bit clear and set need the bit index, which plain issue leaves alone
	task issue_bit(input csf_op_t op, input logic [2:0] bsel, input logic [7:0] src, input logic [8:0] adr);
		exec_bit = bsel;
		issue(op, 8'h00, src, 1'b1, adr);
	endtask : issue_bit
endmodule : csf_exec_model

// [testbench/cpu_status_flag_register_test.sv]
// Self-checking bench for the status flag register.
// Assumes fixed one-cycle latency on status, alu_result and the read port.
`timescale 1ns/100ps
module cpu_status_flag_register_test;
	import csf_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic exec_valid, exec_dest_file;
	csf_op_t exec_op;
	logic [7:0] exec_w, exec_src, rd_data, alu_result, status, fsr_ptr = '0;
	logic [2:0] exec_bit;
	logic [8:0] exec_dest_addr, rd_addr = '0, dir_addr, ind_addr;
	logic wdt_timeout_evt = 1'b0, sleep_evt = 1'b0, wdt_clear_evt = 1'b0, rd_hit;
	logic [6:0] dir_offset = '0;
	int fail_count = 0;
	int total_checks = 0;
	always #50 clk_sys = ~clk_sys;
	csf_exec_model u_exec (.clk_sys(clk_sys), .exec_valid(exec_valid), .exec_op(exec_op), .exec_w(exec_w),
		.exec_src(exec_src), .exec_bit(exec_bit), .exec_dest_file(exec_dest_file), .exec_dest_addr(exec_dest_addr));
	csf_status_reg u_dut (.clk_sys(clk_sys), .srst(srst), .exec_valid(exec_valid), .exec_op(exec_op),
		.exec_w(exec_w), .exec_src(exec_src), .exec_bit(exec_bit), .exec_dest_file(exec_dest_file),
		.exec_dest_addr(exec_dest_addr), .rd_addr(rd_addr), .wdt_timeout_evt(wdt_timeout_evt),
		.sleep_evt(sleep_evt), .wdt_clear_evt(wdt_clear_evt), .dir_offset(dir_offset), .fsr_ptr(fsr_ptr),
		.rd_data(rd_data), .rd_hit(rd_hit), .alu_result(alu_result), .status(status),
		.dir_addr(dir_addr), .ind_addr(ind_addr));
	task check(input string what, input logic [8:0] exp, input logic [8:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	task t_write;
		u_exec.issue(CSF_OP_MOVE_W, 8'he7, 8'h00, 1'b1, 9'h083);
		check("move to status", 9'h0ff, {1'b0, status});
		u_exec.issue(CSF_OP_MOVE_W, 8'h00, 8'h00, 1'b1, 9'h003);
		check("reset-cause bits kept", 9'h018, {1'b0, status});
		u_exec.issue(CSF_OP_MOVE_W, 8'he7, 8'h00, 1'b1, 9'h103);
		u_exec.issue(CSF_OP_CLEAR_FILE, 8'h00, 8'h00, 1'b1, 9'h183);
		check("clear status", 9'h01f, {1'b0, status});
		check("clear result", 9'h000, {1'b0, alu_result});
	endtask : t_write
	task t_add;
		u_exec.issue(CSF_OP_MOVE_W, 8'he0, 8'h00, 1'b1, 9'h003);
		check("flags from data", 9'h0f8, {1'b0, status});
		u_exec.issue(CSF_OP_ADD, 8'h01, 8'hff, 1'b1, 9'h003);
		check("add onto status", 9'h01f, {1'b0, status});
	endtask : t_add
	task t_sub_rot;
		u_exec.issue(CSF_OP_SUB, 8'h01, 8'h12, 1'b0, 9'h003);
		check("sub result", 9'h011, {1'b0, alu_result});
		check("sub no borrow", 9'h003, {6'h00, status[2:0]});
		u_exec.issue(CSF_OP_SUB, 8'h02, 8'h01, 1'b0, 9'h003);
		check("sub borrow", 9'h000, {6'h00, status[2:0]});
		u_exec.issue(CSF_OP_ROT_LEFT, 8'h00, 8'h80, 1'b0, 9'h003);
		check("rotate left", 9'h001, {alu_result, status[0]});
		u_exec.issue(CSF_OP_ROT_RIGHT, 8'h00, 8'h02, 1'b0, 9'h003);
		check("rotate right", 9'h102, {alu_result, status[0]});
	endtask : t_sub_rot
	task t_banks;
		for (int i = 0; i < 4; i++) begin
			u_exec.issue(CSF_OP_MOVE_W, {i[0], i[1:0], 5'h00}, 8'h00, 1'b1, 9'h003);
			dir_offset = 7'h55;
			fsr_ptr = 8'haa;
			#1;
			check("direct address", {i[1:0], 7'h55}, dir_addr);
			check("indirect address", {i[0], 8'haa}, ind_addr);
		end
	endtask : t_banks
	task t_mirror;
		logic [8:0] adrs[5];
		adrs = '{9'h003, 9'h083, 9'h103, 9'h183, 9'h004};
		u_exec.issue(CSF_OP_MOVE_W, 8'h45, 8'h00, 1'b1, 9'h003);
		foreach (adrs[k]) begin
			rd_addr = adrs[k];
			@(negedge clk_sys);
			check("read hit", {8'h00, k < 4}, {8'h00, rd_hit});
			check("read data", (k < 4) ? 9'h05d : 9'h000, {1'b0, rd_data});
		end
	endtask : t_mirror
	task t_events;
		wdt_timeout_evt = 1'b1;
		@(negedge clk_sys);
		wdt_timeout_evt = 1'b0;
		check("time-out", 9'h001, {7'h00, status[4:3]});
		sleep_evt = 1'b1;
		@(negedge clk_sys);
		sleep_evt = 1'b0;
		check("sleep", 9'h002, {7'h00, status[4:3]});
		wdt_clear_evt = 1'b1;
		@(negedge clk_sys);
		wdt_clear_evt = 1'b0;
		check("watchdog clear", 9'h003, {7'h00, status[4:3]});
	endtask : t_events
	task t_logic;
		u_exec.issue_bit(CSF_OP_BIT_SET, 3'h7, 8'h5d, 9'h083);
		check("bit set on status", 9'h0dd, {1'b0, status});
		u_exec.issue_bit(CSF_OP_BIT_CLEAR, 3'h0, 8'hdd, 9'h103);
		check("bit clear on status", 9'h0dc, {1'b0, status});
		u_exec.issue(CSF_OP_SWAP, 8'h00, 8'h3a, 1'b1, 9'h183);
		check("swap on status", 9'h0bb, {1'b0, status});
		u_exec.issue(CSF_OP_AND, 8'h0f, 8'hf0, 1'b1, 9'h003);
		check("and onto status", 9'h01f, {1'b0, status});
		u_exec.issue(CSF_OP_ROT_LEFT, 8'h00, 8'h40, 1'b1, 9'h003);
		check("rotate onto status", 9'h09e, {1'b0, status});
		check("rotate in carry", 9'h081, {1'b0, alu_result});
		u_exec.issue(CSF_OP_IOR, 8'h01, 8'h02, 1'b0, 9'h003);
		check("inclusive or", 9'h006, {alu_result, status[2]});
		u_exec.issue(CSF_OP_XOR, 8'h55, 8'h55, 1'b0, 9'h003);
		check("exclusive or", 9'h001, {alu_result, status[2]});
		u_exec.issue(CSF_OP_COM, 8'h00, 8'h0f, 1'b0, 9'h003);
		check("complement", 9'h1e0, {alu_result, status[2]});
		u_exec.issue(CSF_OP_INC, 8'h00, 8'hff, 1'b0, 9'h003);
		check("increment", 9'h001, {alu_result, status[2]});
		check("increment keeps carries", 9'h09e, {1'b0, status});
		u_exec.issue(CSF_OP_DEC, 8'h00, 8'h00, 1'b0, 9'h003);
		check("decrement", 9'h1fe, {alu_result, status[2]});
		u_exec.issue(CSF_OP_NONE, 8'h00, 8'h3c, 1'b0, 9'h003);
		check("pass through", 9'h03c, {1'b0, alu_result});
		check("pass keeps flags", 9'h09a, {1'b0, status});
	endtask : t_logic
	initial begin
		repeat (2) @(negedge clk_sys);
		srst = 1'b0;
		check("reset value", 9'h018, {1'b0, status});
		t_write();
		t_add();
		t_sub_rot();
		t_banks();
		t_mirror();
		t_events();
		t_logic();
		conclude();
	end
	// A hang would otherwise run forever; the limit counts as a mismatch
	initial begin
		#1ms;
		fail_count++;
		conclude();
	end
endmodule : cpu_status_flag_register_test
